//--- hdl/ucsr_top.v
/*
  UART control and status registers: Wishbone classic slave with 8-bit data, control
  outputs to a bit-timing engine and status inputs from it.
  Assumes the engine runs on CLK_I and gives one-cycle pulses; clock pins are asynchronous.
*/
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "ucsr_consts.vh"

// Contract
// - Soft reset bit holds transceiver in reset
// - Bit 6 inverts the external serial clock
// - Bits 5-4 pick the baud clock source
// - Bit 3 enables receive start-edge detect
// - Bit 2 marks next frame as address
// - Bit 0 reads transmitter empty
// - Sixteen-bit divider, software keeps it legal
// - Modulation byte drives baud modulation
// - Receive buffer read clears receive flags
// - Seven-bit mode clears receive buffer msb
// - Transmit buffer holds until taken into the shift register
// - Transmit buffer write clears transmit flag
// - Seven-bit mode clears transmit buffer msb
// - Enable one bit 7: channel zero transmitter
// - Enable one bit 6: channel zero receiver
// - Enable two bit 5: channel one transmitter
// - Enable two bit 4: channel one receiver
// - Other enable bits stored, not acted upon
// - Flags set on empty buffer, received char
module ucsr_top (
  // Clock and reset
  input  wire        CLK_I,
  input  wire        RESET_N_I,
  // Wishbone slave
  input  wire        CYC_I,
  input  wire        STB_I,
  input  wire        WE_I,
  input  wire [3:0]  ADR_I,
  input  wire [0:0]  SEL_I,
  input  wire [7:0]  DAT_I,
  output wire [7:0]  DAT_O,
  output wire        ACK_O,
  // Clock pins, asynchronous
  input  wire        SERIAL_CLK_PIN_I,
  input  wire        AUX_CLK_I,
  input  wire        SUBMAIN_CLK_I,
  // Transmit engine
  input  wire        TX_TAKE_I,
  input  wire        TX_BUSY_I,
  // Receive engine
  input  wire        RX_DONE_I,
  input  wire [7:0]  RX_DATA_I,
  input  wire        RX_FE_I,
  input  wire        RX_PE_I,
  input  wire        RX_BRK_I,
  input  wire        RX_ADDR_I,
  // Engine configuration
  output wire        SOFT_RESET_O,
  output wire        MULTIPROC_ADDR_O,
  output wire        CHAR8_O,
  output wire        START_EDGE_EN_O,
  output wire        TX_ADDR_MARK_O,
  output wire [15:0] BAUD_DIV_O,
  output wire [7:0]  BAUD_MOD_O,
  output wire        INT_SERIAL_CLK_O,
  output wire        BAUD_CLK_O,
  // Transmit data
  output wire [7:0]  TX_DATA_O,
  output wire        TX_VALID_O,
  // Flags and enables
  output wire        TX_FLAG_O,
  output wire        RX_FLAG_O,
  output wire        TX_EN_CH0_O,
  output wire        RX_EN_CH0_O,
  output wire        TX_EN_CH1_O,
  output wire        RX_EN_CH1_O
);

  // Register file
  reg  [7:0]  ctrl_r;
  reg  [7:0]  tctl_r;
  reg  [7:0]  rctl_r;
  reg  [7:0]  rctl_nxt;
  reg  [7:0]  mod_r;
  reg  [7:0]  brlo_r;
  reg  [7:0]  brhi_r;
  reg  [7:0]  rxbuf_r;
  reg  [7:0]  txbuf_r;
  reg  [7:0]  me1_r;
  reg  [7:0]  me2_r;
  reg         tx_full_r;
  reg         tx_flag_r;
  reg         rx_flag_r;
  reg         tx_flag_nxt;
  reg         rx_flag_nxt;
  reg         tx_full_nxt;
  // Bus side
  reg  [7:0]  dat_r;
  reg         ack_r;
  reg  [7:0]  rd_nxt;
  // Clock pins
  reg  [2:0]  sync1_r;
  reg  [2:0]  sync2_r;
  reg         int_clk_r;
  reg         baud_clk_r;

  wire        req;
  wire        wr;
  wire        rd;
  wire        soft_reset_bit;
  wire        char8;
  wire        rx_err;
  wire        rx_take;
  wire        tx_empty;
  wire [2:0]  clk_pins;

  // New request is the first cycle of cyc and stb, before ack
  assign req      = CYC_I & STB_I & ~ack_r;
  assign wr       = req & WE_I & SEL_I[0];
  assign rd       = req & ~WE_I;
  assign soft_reset_bit    = ctrl_r[`UCSR_CTRL_SOFT_RESET_BIT];
  assign char8    = ctrl_r[`UCSR_CTRL_CHAR8];
  assign rx_err   = RX_FE_I | RX_PE_I | RX_BRK_I;
  assign clk_pins = {SUBMAIN_CLK_I, AUX_CLK_I, SERIAL_CLK_PIN_I};

  // Address match, used by writes and by access side effects
  function hit;
    input [3:0] adr;
    input [3:0] idx;
    begin
      hit = (adr == idx);
    end
  endfunction

  // Receiver accepts characters only when enabled and out of soft reset
  assign rx_take  = RX_DONE_I & me1_r[`UCSR_ME1_RX0] & ~soft_reset_bit;

  // Shift register idle and buffer empty, or soft reset forces it
  assign tx_empty = (~TX_BUSY_I & ~tx_full_r) | soft_reset_bit;

  // Two-stage synchronisers for the three clock pins
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= clk_pins[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  // Polarity and source mux; sampled copies lag the pins by three cycles
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      int_clk_r  <= 1'b0;
      baud_clk_r <= 1'b0;
    end else begin
      int_clk_r <= sync2_r[0] ^ tctl_r[`UCSR_TCTL_POL];
      case (tctl_r[`UCSR_TCTL_SRC_LO+1:`UCSR_TCTL_SRC_LO])
        2'b00:   baud_clk_r <= sync2_r[0] ^ tctl_r[`UCSR_TCTL_POL];
        2'b01:   baud_clk_r <= sync2_r[1];
        default: baud_clk_r <= sync2_r[2];
      endcase
    end
  end

  // Receive control next value: software write, then read clear, then hardware set
  always @* begin
    rctl_nxt    = rctl_r;
    rx_flag_nxt = rx_flag_r;
    if (wr && hit(ADR_I, `UCSR_IDX_RCTL)) begin
      rctl_nxt = DAT_I;
    end
    if (wr && hit(ADR_I, `UCSR_IDX_FLAGS)) begin
      rx_flag_nxt = DAT_I[`UCSR_FLG_RX];
    end
    // Buffer read clears error bits, wake bit and flag
    if (rd && hit(ADR_I, `UCSR_IDX_RXBUF)) begin
      rctl_nxt[`UCSR_RCTL_FE]   = 1'b0;
      rctl_nxt[`UCSR_RCTL_PE]   = 1'b0;
      rctl_nxt[`UCSR_RCTL_OE]   = 1'b0;
      rctl_nxt[`UCSR_RCTL_BRK]  = 1'b0;
      rctl_nxt[`UCSR_RCTL_WAKE] = 1'b0;
      rctl_nxt[`UCSR_RCTL_ERR]  = 1'b0;
      rx_flag_nxt               = 1'b0;
    end
    // A new character wins over a clear in the same cycle
    if (rx_take) begin
      if (RX_FE_I) begin
        rctl_nxt[`UCSR_RCTL_FE] = 1'b1;
      end
      if (RX_PE_I) begin
        rctl_nxt[`UCSR_RCTL_PE] = 1'b1;
      end
      if (RX_BRK_I) begin
        rctl_nxt[`UCSR_RCTL_BRK] = 1'b1;
      end
      if (rx_flag_r) begin
        rctl_nxt[`UCSR_RCTL_OE] = 1'b1;
      end
      if (rx_err || rx_flag_r) begin
        rctl_nxt[`UCSR_RCTL_ERR] = 1'b1;
      end
      rctl_nxt[`UCSR_RCTL_WAKE] = RX_ADDR_I;
      // Errored characters need the error enable, wake mode wants addresses
      if ((~rx_err | rctl_r[`UCSR_RCTL_EIE]) &&
          (~rctl_r[`UCSR_RCTL_WIE] | RX_ADDR_I)) begin
        rx_flag_nxt = 1'b1;
      end
    end
    // Soft reset holds FE, OE and the flag clear; PE, BRK and the enables survive
    if (soft_reset_bit) begin
      rctl_nxt[`UCSR_RCTL_FE]  = 1'b0;
      rctl_nxt[`UCSR_RCTL_OE]  = 1'b0;
      rx_flag_nxt              = 1'b0;
    end
  end

  // Transmit buffer and flag next value
  always @* begin
    tx_full_nxt = tx_full_r;
    tx_flag_nxt = tx_flag_r;
    if (wr && hit(ADR_I, `UCSR_IDX_FLAGS)) begin
      tx_flag_nxt = DAT_I[`UCSR_FLG_TX];
    end
    // Engine moved the character into the shift register
    if (TX_TAKE_I && tx_full_r) begin
      tx_full_nxt = 1'b0;
      tx_flag_nxt = 1'b1;
    end
    // A write refills the buffer; same-cycle take hands over the old byte
    if (wr && hit(ADR_I, `UCSR_IDX_TXBUF)) begin
      tx_full_nxt = 1'b1;
      tx_flag_nxt = 1'b0;
    end
    if (soft_reset_bit) begin
      tx_full_nxt = 1'b0;
      tx_flag_nxt = 1'b1;
    end
  end

  // Register writes
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_r    <= `UCSR_RST_CTRL;
      tctl_r    <= `UCSR_RST_TCTL;
      rctl_r    <= `UCSR_RST_ZERO;
      mod_r     <= `UCSR_RST_ZERO;
      brlo_r    <= `UCSR_RST_ZERO;
      brhi_r    <= `UCSR_RST_ZERO;
      txbuf_r   <= `UCSR_RST_ZERO;
      me1_r     <= `UCSR_RST_ZERO;
      me2_r     <= `UCSR_RST_ZERO;
      tx_full_r <= 1'b0;
      tx_flag_r <= 1'b1;
      rx_flag_r <= 1'b0;
    end else begin
      rctl_r    <= rctl_nxt;
      rx_flag_r <= rx_flag_nxt;
      tx_full_r <= tx_full_nxt;
      tx_flag_r <= tx_flag_nxt;
      if (wr && hit(ADR_I, `UCSR_IDX_CTRL)) begin
        ctrl_r <= DAT_I;
      end
      // Bit 0 of transmit control is live status, bits 7 and 1 unused
      if (wr && hit(ADR_I, `UCSR_IDX_TCTL)) begin
        tctl_r <= DAT_I & 8'h7C;
      end
      if (wr && hit(ADR_I, `UCSR_IDX_MOD)) begin
        mod_r <= DAT_I;
      end
      // Divider is not range checked; values below 3 are the user's problem
      if (wr && hit(ADR_I, `UCSR_IDX_BRLO)) begin
        brlo_r <= DAT_I;
      end
      if (wr && hit(ADR_I, `UCSR_IDX_BRHI)) begin
        brhi_r <= DAT_I;
      end
      if (wr && hit(ADR_I, `UCSR_IDX_TXBUF)) begin
        txbuf_r <= {DAT_I[7] & char8, DAT_I[6:0]};
      end
      // Whole byte stored so bits of other modules keep their value
      if (wr && hit(ADR_I, `UCSR_IDX_ME1)) begin
        me1_r <= DAT_I;
      end
      if (wr && hit(ADR_I, `UCSR_IDX_ME2)) begin
        me2_r <= DAT_I;
      end
    end
  end

  // Receive buffer load
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rxbuf_r <= `UCSR_RST_ZERO;
    end else if (rx_take) begin
      rxbuf_r <= {RX_DATA_I[7] & char8, RX_DATA_I[6:0]};
    end
  end

  // Read mux; unmapped indices read zero
  always @* begin
    case (ADR_I)
      `UCSR_IDX_CTRL:  rd_nxt = ctrl_r;
      `UCSR_IDX_TCTL:  rd_nxt = {tctl_r[7:1], tx_empty};
      `UCSR_IDX_RCTL:  rd_nxt = rctl_r;
      `UCSR_IDX_MOD:   rd_nxt = mod_r;
      `UCSR_IDX_BRLO:  rd_nxt = brlo_r;
      `UCSR_IDX_BRHI:  rd_nxt = brhi_r;
      `UCSR_IDX_RXBUF: rd_nxt = rxbuf_r;
      `UCSR_IDX_TXBUF: rd_nxt = txbuf_r;
      `UCSR_IDX_ME1:   rd_nxt = me1_r;
      `UCSR_IDX_ME2:   rd_nxt = me2_r;
      `UCSR_IDX_FLAGS: rd_nxt = {tx_flag_r, rx_flag_r, 6'h00};
      default:         rd_nxt = 8'h00;
    endcase
  end

  // One-cycle ack for every address, so a bad address never hangs the bus
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_r <= 1'b0;
      dat_r <= 8'h00;
    end else begin
      ack_r <= req;
      if (rd) begin
        dat_r <= rd_nxt;
      end
    end
  end

  // Outputs, all straight from flip-flops
  assign DAT_O            = dat_r;
  assign ACK_O            = ack_r;
  assign SOFT_RESET_O     = ctrl_r[`UCSR_CTRL_SOFT_RESET_BIT];
  assign MULTIPROC_ADDR_O = ctrl_r[`UCSR_CTRL_MM];
  assign CHAR8_O          = ctrl_r[`UCSR_CTRL_CHAR8];
  assign START_EDGE_EN_O  = tctl_r[`UCSR_TCTL_SEDGE];
  assign TX_ADDR_MARK_O   = tctl_r[`UCSR_TCTL_WAKE];
  assign BAUD_DIV_O       = {brhi_r, brlo_r};
  assign BAUD_MOD_O       = mod_r;
  assign INT_SERIAL_CLK_O = int_clk_r;
  assign BAUD_CLK_O       = baud_clk_r;
  assign TX_DATA_O        = txbuf_r;
  assign TX_VALID_O       = tx_full_r;
  assign TX_FLAG_O        = tx_flag_r;
  assign RX_FLAG_O        = rx_flag_r;
  assign TX_EN_CH0_O      = me1_r[`UCSR_ME1_TX0];
  assign RX_EN_CH0_O      = me1_r[`UCSR_ME1_RX0];
  assign TX_EN_CH1_O      = me2_r[`UCSR_ME2_TX1];
  assign RX_EN_CH1_O      = me2_r[`UCSR_ME2_RX1];

endmodule

//--- hdl/ucsr_consts.vh
/*
  Register indices, bit positions and reset values of the UART control and status block.
  Assumes it is included by its bare name from the design file.
*/
`ifndef UCSR_CONSTS_VH
`define UCSR_CONSTS_VH

// Register indices on the 4-bit word address
`define UCSR_IDX_CTRL      4'h0
`define UCSR_IDX_TCTL      4'h1
`define UCSR_IDX_RCTL      4'h2
`define UCSR_IDX_MOD       4'h3
`define UCSR_IDX_BRLO      4'h4
`define UCSR_IDX_BRHI      4'h5
`define UCSR_IDX_RXBUF     4'h6
`define UCSR_IDX_TXBUF     4'h7
`define UCSR_IDX_ME1       4'h8
`define UCSR_IDX_ME2       4'h9
`define UCSR_IDX_FLAGS     4'hA

// Control register bits
`define UCSR_CTRL_SOFT_RESET_BIT    0
`define UCSR_CTRL_MM       1
`define UCSR_CTRL_CHAR8    4

// Transmit control bits
`define UCSR_TCTL_EMPTY    0
`define UCSR_TCTL_WAKE     2
`define UCSR_TCTL_SEDGE    3
`define UCSR_TCTL_SRC_LO   4
`define UCSR_TCTL_POL      6

// Receive control bits
`define UCSR_RCTL_ERR      0
`define UCSR_RCTL_WAKE     1
`define UCSR_RCTL_WIE      2
`define UCSR_RCTL_EIE      3
`define UCSR_RCTL_BRK      4
`define UCSR_RCTL_OE       5
`define UCSR_RCTL_PE       6
`define UCSR_RCTL_FE       7

// Module enable and flag bits
`define UCSR_ME1_TX0       7
`define UCSR_ME1_RX0       6
`define UCSR_ME2_TX1       5
`define UCSR_ME2_RX1       4
`define UCSR_FLG_TX        7
`define UCSR_FLG_RX        6

// Reset values
`define UCSR_RST_CTRL      8'h01
`define UCSR_RST_TCTL      8'h00
`define UCSR_RST_ZERO      8'h00

`endif

//--- dv/ucsr_sva.sv
/* Port assertions for the UART control block.
   Bound to ucsr_top; one clock, asynchronous active-low reset. */
`timescale 1ns/1ns
module ucsr_sva (
  // Clock, reset and bus
  input wire       CLK_I, RESET_N_I, CYC_I, STB_I, WE_I, ACK_O,
  input wire [3:0] ADR_I,
  input wire [0:0] SEL_I,
  input wire [7:0] DAT_I, DAT_O, TX_DATA_O,
  // Engine side
  input wire       TX_TAKE_I, RX_DONE_I, RX_FE_I, RX_PE_I, RX_BRK_I, RX_ADDR_I,
  input wire       SOFT_RESET_O, CHAR8_O, TX_VALID_O, TX_FLAG_O, RX_FLAG_O,
  input wire       TX_EN_CH0_O, RX_EN_CH0_O, TX_EN_CH1_O, RX_EN_CH1_O
);
  // Requests taken this edge; ack excludes the second cycle
  wire rq = CYC_I & STB_I & ~ACK_O;
  wire wr = rq & WE_I & SEL_I[0];
  wire rd = rq & ~WE_I;
  wire w7 = wr & (ADR_I == 4'h7);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  AST_SOFT: assert property (SOFT_RESET_O ##1 SOFT_RESET_O |->
    TX_FLAG_O && !TX_VALID_O && !RX_FLAG_O) else $error("soft reset flags");
  AST_TXWR: assert property (w7 && !SOFT_RESET_O |=> TX_VALID_O && !TX_FLAG_O)
    else $error("buffer write flag");
  AST_TAKE: assert property (TX_TAKE_I && TX_VALID_O && !w7 |=>
    TX_FLAG_O && !TX_VALID_O) else $error("take flag");
  AST_HOLD: assert property (TX_VALID_O && !TX_TAKE_I && !SOFT_RESET_O && !w7 |=>
    TX_VALID_O && $stable(TX_DATA_O)) else $error("buffer lost");
  AST_CH7: assert property (w7 && !CHAR8_O && !SOFT_RESET_O |=>
    TX_DATA_O == ($past(DAT_I) & 8'h7f)) else $error("tx msb");
  AST_RXSET: assert property (RX_DONE_I && RX_EN_CH0_O && !SOFT_RESET_O && !RX_FLAG_O
    && RX_ADDR_I && !(RX_FE_I | RX_PE_I | RX_BRK_I) |=> RX_FLAG_O) else $error("rx flag");
  AST_RXOFF: assert property (RX_DONE_I && !RX_EN_CH0_O && !RX_FLAG_O && !wr |=>
    !RX_FLAG_O) else $error("rx while off");
  AST_RDCLR: assert property (rd && ADR_I == 4'h6 && !RX_DONE_I |=> !RX_FLAG_O)
    else $error("read clear");
  AST_EMPTY: assert property (rd && ADR_I == 4'h1 && !SOFT_RESET_O && TX_VALID_O |=>
    !DAT_O[0]) else $error("empty bit");
  AST_ME1: assert property (wr && ADR_I == 4'h8 |=>
    {TX_EN_CH0_O, RX_EN_CH0_O, 6'h00} == ($past(DAT_I) & 8'hc0)) else $error("enable one");
  AST_ME2: assert property (wr && ADR_I == 4'h9 |=>
    {2'b00, TX_EN_CH1_O, RX_EN_CH1_O, 4'h0} == ($past(DAT_I) & 8'h30)) else $error("enable two");
endmodule

bind ucsr_top ucsr_sva i_sva (.*);

//--- dv/ucsr_eng_model.sv
/* Behavioural bit-timing engine facing the control block.
   Assumes the bench commands each received character. */
`timescale 1ns/1ns
module ucsr_eng_model (
  // Clock, reset and commands
  input wire       clk_i, rst_n_i, stall_i, rx_go_i, tx_valid_i,
  input wire [7:0] rx_char_i,
  input wire [3:0] rx_kind_i,
  // Toward the control block
  output reg       tx_take_o, tx_busy_o, rx_done_o, rx_fe_o, rx_pe_o, rx_brk_o, rx_addr_o,
  output reg [7:0] rx_data_o
);
  reg [3:0] cnt_r;
  // Take a full buffer when idle, then shift ten cycles
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_take_o <= 1'b0;
      tx_busy_o <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      tx_take_o <= 1'b0;
      if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      if (tx_valid_i && !tx_busy_o && !tx_take_o && !stall_i) begin
        tx_take_o <= 1'b1;
        tx_busy_o <= 1'b1;
        cnt_r <= 4'ha;
      end else if (cnt_r == 4'h0)
        tx_busy_o <= 1'b0;
    end
  end
  // Qualifiers valid with done only; scrambled otherwise so stale data never passes
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      {rx_done_o, rx_data_o, rx_fe_o, rx_pe_o, rx_brk_o, rx_addr_o} <= 13'h0000;
    else if (rx_go_i)
      {rx_done_o, rx_data_o, rx_fe_o, rx_pe_o, rx_brk_o, rx_addr_o} <=
        {1'b1, rx_char_i, rx_kind_i};
    else
      {rx_done_o, rx_data_o, rx_fe_o, rx_pe_o, rx_brk_o, rx_addr_o} <=
        {1'b0, ~rx_data_o, ~rx_fe_o, ~rx_pe_o, ~rx_brk_o, ~rx_addr_o};
  end
endmodule

//--- dv/tb_top.sv
/* Self-checking bench for the UART control block.
   Assumes the engine model file and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module tb_top;
  reg        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, go = 0, stall = 0;
  reg        pin = 0, aux = 1, sub = 0, sel = 1;
  reg  [3:0] adr = 4'h0, kind = 4'h0;
  reg  [7:0] dat = 8'h00, ch = 8'h00, q;
  wire       ack, take, busy, done, fe, pe, break_detected, ad, sres, mpa, c8, sed, tam, iclk, bclk;
  wire       txv, txf, rxf, te0, re0, te1, re1;
  wire [7:0] dato, rxd, txd, bmod;
  wire [15:0] bdiv;
  integer    failures = 0, checks = 0;
  // Clock, 4 ns period
  always #2 clk = ~clk;
  ucsr_top i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack),
    .SERIAL_CLK_PIN_I(pin), .AUX_CLK_I(aux), .SUBMAIN_CLK_I(sub), .TX_TAKE_I(take),
    .TX_BUSY_I(busy), .RX_DONE_I(done), .RX_DATA_I(rxd), .RX_FE_I(fe), .RX_PE_I(pe),
    .RX_BRK_I(break_detected), .RX_ADDR_I(ad), .SOFT_RESET_O(sres), .MULTIPROC_ADDR_O(mpa),
    .CHAR8_O(c8), .START_EDGE_EN_O(sed), .TX_ADDR_MARK_O(tam), .BAUD_DIV_O(bdiv),
    .BAUD_MOD_O(bmod), .INT_SERIAL_CLK_O(iclk), .BAUD_CLK_O(bclk), .TX_DATA_O(txd),
    .TX_VALID_O(txv), .TX_FLAG_O(txf), .RX_FLAG_O(rxf), .TX_EN_CH0_O(te0),
    .RX_EN_CH0_O(re0), .TX_EN_CH1_O(te1), .RX_EN_CH1_O(re1));
  ucsr_eng_model i_eng (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .rx_go_i(go),
    .tx_valid_i(txv), .rx_char_i(ch), .rx_kind_i(kind), .tx_take_o(take),
    .tx_busy_o(busy), .rx_done_o(done), .rx_fe_o(fe), .rx_pe_o(pe), .rx_brk_o(break_detected),
    .rx_addr_o(ad), .rx_data_o(rxd));
  task chk(input [15:0] s, input [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then one idle cycle
  task wb(input w, input [3:0] a, input [7:0] d);
    integer n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 40);
    if (n >= 40) failures++;
    q = dato;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  // One character from the engine; flags settle two edges later
  task rx(input [7:0] c, input [3:0] k);
    go <= 1'b1; ch <= c; kind <= k;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task t_reset;
    wb(0, 4'h0, 0); chk(q, 8'h01);
    wb(0, 4'h1, 0); chk(q, 8'h01);
    wb(0, 4'ha, 0); chk(q, 8'h80);
    wb(0, 4'hb, 0); chk(q, 8'h00);
    chk({txf, rxf, txv, sres}, 4'b1001);
  endtask
  task t_clk;
    // Second pass flips every clock pin, so each source is seen at both levels
    for (int k = 0; k < 16; k++) begin
      pin <= k[3];
      aux <= !k[3];
      sub <= k[3];
      wb(1, 4'h1, {1'b0, k[2], k[1:0], k[0], k[1], 2'b00});
      repeat (4) @(posedge clk);
      chk(bclk, k[1] ? k[3] : (k[0] ? !k[3] : (k[2] ^ k[3])));
      chk(iclk, k[2] ^ k[3]);
      chk({sed, tam}, {k[0], k[1]});
    end
  endtask
  task t_div;
    wb(1, 4'h4, 8'hfe); wb(1, 4'h5, 8'hff); chk(bdiv, 16'hfffe);
    wb(1, 4'h4, 8'h03); wb(1, 4'h5, 8'h00); chk(bdiv, 16'h0003);
    wb(1, 4'h3, 8'ha5); chk(bmod, 8'ha5);
    // Write with the byte lane off must leave the register alone
    sel <= 1'b0;
    wb(1, 4'h3, 8'h00); chk(bmod, 8'ha5);
    sel <= 1'b1;
    wb(1, 4'h0, 8'h13); chk({mpa, c8, sres}, 3'b111);
    wb(1, 4'h0, 8'h10); chk({mpa, c8, sres}, 3'b010);
  endtask
  task t_me;
    wb(1, 4'h8, 8'h7f); chk({te0, re0}, 2'b01);
    wb(0, 4'h8, 0); chk(q, 8'h7f);
    wb(1, 4'h9, 8'h20); chk({te1, re1}, 2'b10);
    wb(1, 4'h9, 8'hd0); chk({te1, re1}, 2'b01);
    wb(0, 4'h9, 0); chk(q, 8'hd0);
    wb(1, 4'h8, 8'hc0); chk({te0, re0}, 2'b11);
    // Flag register is writable; leave it with only the transmit flag up
    wb(1, 4'ha, 8'h40); chk({txf, rxf}, 2'b01);
    wb(1, 4'ha, 8'h80); chk({txf, rxf}, 2'b10);
  endtask
  task t_tx;
    stall <= 1'b1;
    wb(1, 4'h7, 8'hc3); chk({txv, txf, txd}, {2'b10, 8'hc3});
    wb(0, 4'h1, 0); chk(q[0], 1'b0);
    repeat (5) @(posedge clk);
    chk(txd, 8'hc3);
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    chk({txv, txf}, 2'b01);
    repeat (12) @(posedge clk);
    wb(0, 4'h1, 0); chk(q[0], 1'b1);
    wb(1, 4'h0, 8'h00);
    stall <= 1'b1;
    wb(1, 4'h7, 8'hff); chk(txd, 8'h7f);
    stall <= 1'b0;
    repeat (15) @(posedge clk);
  endtask
  task t_rx;
    rx(8'hff, 4'h1); chk(rxf, 1'b1);
    wb(0, 4'h2, 0); chk(q, 8'h02);
    rx(8'hd5, 4'h0);
    wb(0, 4'h2, 0); chk(q, 8'h21);
    wb(0, 4'h6, 0); chk(q, 8'h55);
    chk(rxf, 1'b0);
    wb(0, 4'h2, 0); chk(q, 8'h00);
    rx(8'h11, 4'h8); chk(rxf, 1'b0);
    wb(0, 4'h2, 0); chk(q, 8'h81);
    wb(0, 4'h6, 0);
    wb(1, 4'h2, 8'h08);
    rx(8'h22, 4'h2); chk(rxf, 1'b1);
    wb(0, 4'h2, 0); chk(q, 8'h19);
    wb(0, 4'h6, 0);
    rx(8'h33, 4'h4);
    wb(0, 4'h2, 0); chk(q, 8'h49);
    // Drain the pending character so the wake-mode checks start clean
    wb(0, 4'h6, 0);
    wb(1, 4'h2, 8'h04);
    rx(8'h44, 4'h0); chk(rxf, 1'b0);
    rx(8'h45, 4'h1); chk(rxf, 1'b1);
    wb(0, 4'h6, 0); chk(q, 8'h45);
    wb(1, 4'h8, 8'h80);
    rx(8'h66, 4'h1); chk(rxf, 1'b0);
  endtask
  task t_soft;
    wb(1, 4'h8, 8'hc0);
    stall <= 1'b1;
    wb(1, 4'h7, 8'h12);
    wb(1, 4'h0, 8'h01);
    repeat (2) @(posedge clk);
    chk({txv, txf}, 2'b01);
    wb(0, 4'h1, 0); chk(q[0], 1'b1);
    rx(8'h77, 4'h1); chk(rxf, 1'b0);
  endtask
  task give_verdict;
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset; t_clk; t_div; t_me; t_tx; t_rx; t_soft;
    give_verdict;
  end
  // Watchdog, well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict;
  end
endmodule
